//--- fhp_regs.svh
// register offsets, field positions, reset values and the system clock rate
// Operation
// RULE_01: host accesses are honoured only while the active-low select is low.
// RULE_02: address and direction lines are sampled only during selected phase two.
// RULE_03: selected read drives the addressed register onto the data lines.
// RULE_04: selected write captures the data lines into the addressed register.
// RULE_05: code 0 status/command, 1 track, 2 sector, 3 data.
// RULE_06: data lines are 8-bit, bidirectional, non-inverting, three-state.
// RULE_07: interrupt output pulls low when an operation completes or terminates.
// RULE_08: interrupt released by a new command write or a status read.
// RULE_09: reset clears internal state and presets the command register to 03.
// RULE_10: reset clears the not-ready status bit 7.
// RULE_11: on reset release a restore starts and sector register loads 01.
// RULE_12: data request rises when a byte waits (read) or buffer empty (write).
// RULE_13: data request clears on host data read (read) or data load (write).
// RULE_14: the system supplies a 2 MHz or 1 MHz square timing clock; the bench drives its 100 MHz clk_sys in its place.
// RULE_15: data lines stay undriven except during a selected read in phase two.
`ifndef FHP_REGS_SVH
`define FHP_REGS_SVH
`define FHP_ADDR_STATUS 2'h0
`define FHP_ADDR_TRACK 2'h1
`define FHP_ADDR_SECTOR 2'h2
`define FHP_ADDR_DATA 2'h3
`define FHP_CMD_RESET 8'h03
`define FHP_SECTOR_RESET 8'h01
`define FHP_STAT_NOT_READY 7
`define FHP_STAT_BUSY 0
`define FHP_STAT_DRQ 1
`define FHP_CLK_SYS_MHZ 100
`endif

//--- fhp_pkg.sv
// types shared by the host port
package fhp_pkg;
   typedef enum logic [1:0] {FHP_IDLE, FHP_ACCESS, FHP_DONE} fhp_state_t;
endpackage

//--- fhp_edge.sv
// rising and falling edge detector for the phase-two qualified strobe
module fhp_edge
   import fhp_pkg::*;
(
   // clocking
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // level in, pulses out
   input wire logic level_in,
   output logic rise_o,
   output logic fall_o
);
   typedef struct packed {
      logic prev;
   } fhp_edge_st_t;
   fhp_edge_st_t st_r;
   fhp_edge_st_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.prev = level_in;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else if (clk_en)
         st_r <= st_nxt;
   end

   assign rise_o = clk_en & level_in & ~st_r.prev;
   assign fall_o = clk_en & ~level_in & st_r.prev;
endmodule

//--- fhp_port.sv
// processor bus port of the floppy controller with its host-visible registers
`include "fhp_regs.svh"
module fhp_port
   import fhp_pkg::*;
(
   // clocking
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // processor bus
   input wire logic select_n,
   input wire logic phi2,
   input wire logic rd_wr,
   input wire logic [1:0] register_address_lines,
   input wire logic [7:0] host_data_lines_i,
   output logic [7:0] host_data_lines_o,
   output logic host_data_lines_oe,
   // open-drain requests, oe high pulls the line low
   output logic irq_oe,
   output logic byte_transfer_request_oe,
   // controller core side
   input wire logic op_done,
   input wire logic xfer_read,
   input wire logic xfer_write,
   input wire logic core_byte_valid,
   input wire logic [7:0] core_byte,
   input wire logic core_byte_taken,
   input wire logic [6:0] core_status,
   input wire logic core_track_load,
   input wire logic [7:0] core_track,
   output logic [7:0] command_o,
   output logic command_stb,
   output logic restore_stb,
   output logic [7:0] track_o,
   output logic [7:0] sector_o,
   output logic [7:0] data_o
);
   typedef struct packed {
      fhp_state_t state;
      logic [1:0] addr;
      logic dir_rd;
      logic [7:0] cmd;
      logic [7:0] track;
      logic [7:0] sector;
      logic [7:0] data;
      logic irq;
      logic byte_transfer_request;
      logic not_ready;
      logic cmd_stb;
      logic restore;
      logic boot;
      logic [7:0] dout;
      logic [7:0] wdat;
   } fhp_st_t;

   fhp_st_t st_r;
   fhp_st_t st_nxt;
   logic strobe;
   logic acc_rise;
   logic acc_fall;

   assign strobe = phi2 & ~select_n; // [RULE_01] [RULE_02]

   fhp_edge u_edge (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .level_in(strobe),
      .rise_o(acc_rise),
      .fall_o(acc_fall)
   );

   function automatic logic [7:0] read_mux(input fhp_st_t s,
                                           input logic [1:0] a,
                                           input logic [6:0] cs);
      case (a)
         `FHP_ADDR_STATUS: read_mux = {s.not_ready, cs[6:2], s.byte_transfer_request, cs[0]};
         `FHP_ADDR_TRACK: read_mux = s.track;
         `FHP_ADDR_SECTOR: read_mux = s.sector;
         default: read_mux = s.data;
      endcase
   endfunction

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.cmd_stb = 1'b0;
      st_nxt.restore = 1'b0;
      // restore fires once, on the first enabled cycle after release
      if (st_r.boot)
      begin
         st_nxt.boot = 1'b0;
         st_nxt.restore = 1'b1; // [RULE_11]
      end
      if (core_track_load)
         st_nxt.track = core_track;
      // core events set; host clears below may be overridden by them
      if (core_byte_valid && xfer_read)
         st_nxt.data = core_byte;
      case (st_r.state)
         FHP_IDLE:
         begin
            if (acc_rise)
            begin
               // address and direction latched only at qualified phase two
               st_nxt.addr = register_address_lines; // [RULE_02]
               st_nxt.dir_rd = rd_wr;
               st_nxt.dout = read_mux(st_r, register_address_lines,
                                      core_status); // [RULE_03] [RULE_05]
               st_nxt.state = FHP_ACCESS;
            end
         end
         FHP_ACCESS:
         begin
            // write data is taken while the strobe is still high: the host
            // may drop its data together with phase two
            if (strobe)
               st_nxt.wdat = host_data_lines_i; // [RULE_04]
            if (acc_fall)
            begin
               st_nxt.state = FHP_DONE;
               if (!st_r.dir_rd)
               begin
                  case (st_r.addr) // [RULE_04] [RULE_05]
                     `FHP_ADDR_STATUS:
                     begin
                        st_nxt.cmd = st_r.wdat;
                        st_nxt.cmd_stb = 1'b1;
                        st_nxt.irq = 1'b0; // [RULE_08]
                     end
                     `FHP_ADDR_TRACK: st_nxt.track = st_r.wdat;
                     `FHP_ADDR_SECTOR: st_nxt.sector = st_r.wdat;
                     default:
                     begin
                        st_nxt.data = st_r.wdat;
                        if (xfer_write)
                           st_nxt.byte_transfer_request = 1'b0; // [RULE_13]
                     end
                  endcase
               end
               else if (st_r.addr == `FHP_ADDR_STATUS)
                  st_nxt.irq = 1'b0; // [RULE_08]
               else if (st_r.addr == `FHP_ADDR_DATA && xfer_read)
                  st_nxt.byte_transfer_request = 1'b0; // [RULE_13]
            end
         end
         FHP_DONE: st_nxt.state = FHP_IDLE;
         default: st_nxt.state = FHP_IDLE;
      endcase
      // set wins over a same-cycle clear
      if (op_done)
         st_nxt.irq = 1'b1; // [RULE_07]
      if ((xfer_read && core_byte_valid) || (xfer_write && core_byte_taken))
         st_nxt.byte_transfer_request = 1'b1; // [RULE_12]
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= '0; // [RULE_09] [RULE_10]
         st_r.cmd <= `FHP_CMD_RESET; // [RULE_09]
         st_r.sector <= `FHP_SECTOR_RESET; // [RULE_11]
         st_r.boot <= 1'b1;
         st_r.state <= FHP_IDLE;
      end
      else if (clk_en)
         st_r <= st_nxt;
   end

   // bus driven only inside a selected read high phase
   assign host_data_lines_oe = strobe & rd_wr & (st_r.state == FHP_ACCESS);
   // [RULE_06] [RULE_15]
   assign host_data_lines_o = st_r.dout; // [RULE_03]
   assign irq_oe = st_r.irq; // [RULE_07]
   // request is active high: release (oe low) lets pull-up raise it
   assign byte_transfer_request_oe = ~st_r.byte_transfer_request; // [RULE_12]
   assign command_o = st_r.cmd;
   assign command_stb = st_r.cmd_stb;
   assign restore_stb = st_r.restore;
   assign track_o = st_r.track;
   assign sector_o = st_r.sector;
   assign data_o = st_r.data;

   // checks
   a_irq_set_by_done: assert property ( // [RULE_07]
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && op_done |=> irq_oe)
      else $error("irq not raised after done");
   a_irq_clr_status: assert property ( // [RULE_08]
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && acc_fall && st_r.dir_rd && st_r.addr == 2'h0 && !op_done
      |=> !irq_oe)
      else $error("irq not released by status read");
   // write data is the last value seen with the strobe still high
   a_cmd_write_stb: assert property ( // [RULE_04]
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && $past(clk_en) && acc_fall && !st_r.dir_rd
      && st_r.addr == 2'h0
      |=> command_stb && command_o == $past(host_data_lines_i, 2))
      else $error("command write lost");
   a_bus_idle_unsel: assert property ( // [RULE_15]
      @(posedge clk_sys) disable iff (!rst_n)
      select_n |-> !host_data_lines_oe)
      else $error("bus driven while unselected");
   a_bus_write_hiz: assert property ( // [RULE_06]
      @(posedge clk_sys) disable iff (!rst_n)
      !rd_wr |-> !host_data_lines_oe)
      else $error("bus driven in write");
   a_drq_set_read: assert property ( // [RULE_12]
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && xfer_read && core_byte_valid
      |=> !byte_transfer_request_oe && data_o == $past(core_byte))
      else $error("read byte not requested");
   a_drq_clr_read: assert property ( // [RULE_13]
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && acc_fall && st_r.dir_rd && st_r.addr == 2'h3 && xfer_read
      && !core_byte_valid |=> byte_transfer_request_oe)
      else $error("request not cleared by data read");
   a_sector_write: assert property ( // [RULE_05]
      @(posedge clk_sys) disable iff (!rst_n)
      clk_en && $past(clk_en) && acc_fall && !st_r.dir_rd
      && st_r.addr == 2'h2 |=> sector_o == $past(host_data_lines_i, 2))
      else $error("sector write lost");
   a_no_access_unsel: assert property ( // [RULE_01]
      @(posedge clk_sys) disable iff (!rst_n)
      select_n && st_r.state == FHP_IDLE |=> st_r.state != FHP_ACCESS)
      else $error("access while unselected");
   a_restore_once: assert property ( // [RULE_11]
      @(posedge clk_sys) disable iff (!rst_n)
      restore_stb |=> !restore_stb)
      else $error("restore repeated");

   c_status_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
      acc_fall && st_r.dir_rd && st_r.addr == 2'h0);
   c_cmd_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
      command_stb);
   c_data_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
      acc_fall && st_r.dir_rd && st_r.addr == 2'h3 && xfer_read);
endmodule

//--- fhp_cpu_model.sv
// processor bus model: select, phase-two strobe, direction, address, data
module fhp_cpu_model
(
   // clock and resolved data lines
   input wire logic clk_sys,
   input wire logic [7:0] dbus,
   // bus signals driven by the processor
   output logic select_n,
   output logic phi2,
   output logic rd_wr,
   output logic [1:0] addr,
   output logic [7:0] dout
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      select_n = 1'b1;
      phi2 = 1'b0;
      rd_wr = 1'b1;
      addr = 2'h0;
      dout = 8'h00;
   end
   // strobe held four edges and released for four, above the two-cycle
   // minimum, so no rise is lost in the port's FHP_DONE cycle
   task automatic acc(input logic sel_n, input logic rd, input logic [1:0] a,
      input logic [7:0] wd, output logic [7:0] rdat);
      @(posedge clk_sys);
      select_n <= sel_n;
      phi2 <= 1'b1;
      rd_wr <= rd;
      addr <= a;
      dout <= wd;
      repeat (3) @(posedge clk_sys);
      rdat = dbus;
      @(posedge clk_sys);
      select_n <= 1'b1;
      phi2 <= 1'b0;
      rd_wr <= 1'b1;
      // a released bus must not keep showing the last byte
      dout <= ~wd;
      repeat (3) @(posedge clk_sys);
   endtask
endmodule

//--- test_floppy_ctrl_host_bus_port.sv
// self-checking bench for the processor bus port
module test_floppy_ctrl_host_bus_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic op_done = 1'b0;
   logic xfer_read = 1'b0;
   logic xfer_write = 1'b0;
   logic core_byte_valid = 1'b0;
   logic core_byte_taken = 1'b0;
   logic [7:0] core_byte = 8'h00;
   // bit 1 set on purpose: the port must show its own request flag there
   logic [6:0] core_status = 7'h43;
   logic select_n, phi2, rd_wr, hd_oe, irq_oe, drq_oe, command_stb, restore_stb;
   logic [1:0] ra;
   logic [7:0] hd_o, cpu_d, command_o, track_o, sector_o, data_o;
   wire [7:0] dbus = hd_oe ? hd_o : cpu_d;
   int n_fail = 0;
   int comparisons = 0;
   int n_restore = 0;
   int n_cmd = 0;
   fhp_cpu_model u_fhp_cpu_model (.clk_sys(clk_sys), .dbus(dbus),
      .select_n(select_n), .phi2(phi2), .rd_wr(rd_wr), .addr(ra),
      .dout(cpu_d));
   fhp_port u_fhp_port (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
      .select_n(select_n), .phi2(phi2), .rd_wr(rd_wr),
      .register_address_lines(ra), .host_data_lines_i(dbus),
      .host_data_lines_o(hd_o), .host_data_lines_oe(hd_oe), .irq_oe(irq_oe),
      .byte_transfer_request_oe(drq_oe), .op_done(op_done),
      .xfer_read(xfer_read), .xfer_write(xfer_write),
      .core_byte_valid(core_byte_valid), .core_byte(core_byte),
      .core_byte_taken(core_byte_taken), .core_status(core_status),
      .core_track_load(1'b0), .core_track(8'h00), .command_o(command_o),
      .command_stb(command_stb), .restore_stb(restore_stb),
      .track_o(track_o), .sector_o(sector_o), .data_o(data_o));
   // the bench clock also stands in for the square-wave timing reference
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      if (restore_stb === 1'b1)
         n_restore++;
   always @(posedge clk_sys)
      if (command_stb === 1'b1)
         n_cmd++;
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask
   task stop_test;
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task t_reset;
      logic [7:0] r;
      chk(command_o, 8'h03);
      chk(sector_o, 8'h01);
      chk(n_restore[7:0], 8'h01);
      u_fhp_cpu_model.acc(1'b0, 1'b1, 2'h0, 8'h00, r);
      chk({7'h0, r[7]}, 8'h00);
      chk(r, 8'h41);
   endtask
   task t_regs;
      logic [7:0] r;
      for (int a = 1; a < 4; a++)
      begin
         u_fhp_cpu_model.acc(1'b0, 1'b0, 2'(a), 8'h50 + 8'(a), r);
         u_fhp_cpu_model.acc(1'b0, 1'b1, 2'(a), 8'h00, r);
         chk(r, 8'h50 + 8'(a));
      end
      chk(track_o, 8'h51);
      chk(sector_o, 8'h52);
      chk(data_o, 8'h53);
      chk({7'h0, hd_oe}, 8'h00);
   endtask
   task t_select;
      logic [7:0] r;
      u_fhp_cpu_model.acc(1'b1, 1'b0, 2'h1, 8'hee, r);
      // an unselected read must leave the host's own pattern on the lines
      u_fhp_cpu_model.acc(1'b1, 1'b1, 2'h1, 8'h77, r);
      chk(r, 8'h77);
      u_fhp_cpu_model.acc(1'b0, 1'b1, 2'h1, 8'h00, r);
      chk(r, 8'h51);
   endtask
   task t_irq;
      logic [7:0] r;
      for (int k = 0; k < 2; k++)
      begin
         @(posedge clk_sys);
         op_done <= 1'b1;
         @(posedge clk_sys);
         op_done <= 1'b0;
         repeat (2) @(posedge clk_sys);
         chk({7'h0, irq_oe}, 8'h01);
         u_fhp_cpu_model.acc(1'b0, k == 0, 2'h0, 8'h0c, r);
         chk({7'h0, irq_oe}, 8'h00);
      end
      chk(command_o, 8'h0c);
      chk(n_cmd[7:0], 8'h01);
   endtask
   task t_drq;
      logic [7:0] r;
      @(posedge clk_sys);
      xfer_read <= 1'b1;
      core_byte <= 8'h3c;
      core_byte_valid <= 1'b1;
      @(posedge clk_sys);
      core_byte_valid <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({7'h0, drq_oe}, 8'h00);
      u_fhp_cpu_model.acc(1'b0, 1'b1, 2'h3, 8'h00, r);
      chk(r, 8'h3c);
      chk({7'h0, drq_oe}, 8'h01);
      xfer_read <= 1'b0;
      xfer_write <= 1'b1;
      core_byte_taken <= 1'b1;
      @(posedge clk_sys);
      core_byte_taken <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({7'h0, drq_oe}, 8'h00);
      u_fhp_cpu_model.acc(1'b0, 1'b0, 2'h3, 8'hc3, r);
      chk({7'h0, drq_oe}, 8'h01);
      chk(data_o, 8'hc3);
   endtask
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset;
      t_regs;
      t_select;
      t_irq;
      t_drq;
      stop_test;
   end
   // the sequence needs about 140 cycles; allow well over that
   initial
   begin
      #100us;
      n_fail++;
      stop_test;
   end
endmodule
